// ---- rtl/csoir_pkg.sv ----
// Shared constants for the core status, option and interrupt register set.
// Assumes a 9-bit data-memory address formed by the core from the bank bits.
`default_nettype none

package csoir_pkg;

   // ------------------------------------------------------------------
   // data memory addressing
   // ------------------------------------------------------------------
   localparam int ADDR_W = 9;
   localparam int BANK_BYTES = 128;
   localparam logic [8:0] ADDR_ARITH_STATUS = 9'h003;
   localparam logic [8:0] ADDR_CORE_IRQ_CTRL = 9'h00B;
   localparam logic [8:0] ADDR_PRESCALE_OPTION = 9'h081;
   localparam logic [8:0] ADDR_PERIPH_IRQ_EN = 9'h08C;
   // address bits compared; cleared bits are the mirrored bank bits
   localparam logic [8:0] MIRROR_ALL_BANKS = 9'h07F;
   localparam logic [8:0] MIRROR_ODD_BANKS = 9'h0FF;
   localparam logic [8:0] MIRROR_NONE = 9'h1FF;

   // ------------------------------------------------------------------
   // arith_status_bank fields
   // ------------------------------------------------------------------
   localparam int BIT_IND_BANK = 7;
   localparam int BIT_DBANK_HI = 6;
   localparam int BIT_DBANK_LO = 5;
   localparam int BIT_WDOG_EXPIRY = 4;
   localparam int BIT_POWER_DOWN = 3;
   localparam int BIT_RES_NULL = 2;
   localparam int BIT_NIBBLE_OVF = 1;
   localparam int BIT_MSB_OVF = 0;

   // ------------------------------------------------------------------
   // timer_prescale_option fields
   // ------------------------------------------------------------------
   localparam int BIT_PULLUP_DIS = 7;
   localparam int BIT_EXT_EDGE = 6;
   localparam int BIT_T0_SRC = 5;
   localparam int BIT_T0_EDGE = 4;
   localparam int BIT_PRESC_ASSIGN = 3;
   localparam int BIT_RATE_HI = 2;
   localparam int BIT_RATE_LO = 0;
   localparam logic [3:0] T0_RATE_OFFSET = 4'h1;

   // ------------------------------------------------------------------
   // core_interrupt_control fields
   // ------------------------------------------------------------------
   localparam int BIT_GLOBAL_EN = 7;
   localparam int BIT_PERIPH_GRP_EN = 6;
   localparam int BIT_T0OVF_EN = 5;
   localparam int BIT_EXTPIN_EN = 4;
   localparam int BIT_PORTCHG_EN = 3;
   localparam int BIT_T0OVF_FLAG = 2;
   localparam int BIT_EXTPIN_FLAG = 1;
   localparam int BIT_PORTCHG_FLAG = 0;

   // ------------------------------------------------------------------
   // reset values and write masks
   // ------------------------------------------------------------------
   localparam logic [7:0] RST_ARITH_STATUS = 8'h18;
   localparam logic [7:0] RST_CORE_IRQ_CTRL = 8'h00;
   localparam logic [7:0] RST_PRESCALE_OPTION = 8'hFF;
   localparam logic [7:0] RST_PERIPH_IRQ_EN = 8'h00;
   localparam logic [7:0] PERIPH_IRQ_EN_WR_MASK = 8'h4F;

   // ------------------------------------------------------------------
   // flag-affecting operation kinds
   // ------------------------------------------------------------------
   typedef enum logic [4:0] {
      CSOIR_OP_ADD = 5'h01,
      CSOIR_OP_SUB = 5'h02,
      CSOIR_OP_ROT_RIGHT = 5'h04,
      CSOIR_OP_ROT_LEFT = 5'h08,
      CSOIR_OP_LOGIC = 5'h10
   } csoir_op_e;

endpackage : csoir_pkg

`default_nettype wire

// ---- rtl/csoir_flag_calc.sv ----
// Computes result-null, nibble overflow and msb overflow for one operation.
// Assumes operands are stable for the cycle in which the core applies them.
`default_nettype none

module csoir_flag_calc (
   // operation
   input wire csoir_pkg::csoir_op_e aluOp,
   input wire logic [7:0] opA,
   input wire logic [7:0] opB,
   input wire logic [7:0] logicResult,
   input wire logic carryIn,
   // flags
   output logic resultNull,
   output logic nibbleOvf,
   output logic msbOvf
);
   import csoir_pkg::*;

   logic isSub;
   logic [7:0] addend;
   logic [8:0] sum;
   logic [4:0] nibSum;
   logic [7:0] result;

   // subtraction adds the two's complement, so borrow reads inverted
   assign isSub = (aluOp == CSOIR_OP_SUB);
   assign addend = isSub ? ~opB : opB;
   assign sum = {1'b0, opA} + {1'b0, addend} + {8'h00, isSub};
   assign nibSum = {1'b0, opA[3:0]} + {1'b0, addend[3:0]} + {4'h0, isSub};

   always_comb begin
      unique case (aluOp)
         CSOIR_OP_ADD, CSOIR_OP_SUB: begin
            result = sum[7:0];
            msbOvf = sum[8];
         end
         CSOIR_OP_ROT_RIGHT: begin
            result = {carryIn, opA[7:1]};
            msbOvf = opA[0];
         end
         CSOIR_OP_ROT_LEFT: begin
            result = {opA[6:0], carryIn};
            msbOvf = opA[7];
         end
         default: begin
            result = logicResult;
            msbOvf = carryIn;
         end
      endcase
   end

   assign nibbleOvf = nibSum[4];
   assign resultNull = (result == 8'h00);

endmodule : csoir_flag_calc

`default_nettype wire

// ---- rtl/csoir_prescaler.sv ----
// Shared prescaler: divides the timer0 source or postscales the watchdog.
// Assumes source ticks and the external clock pin are synchronous to ref_clk.
`default_nettype none

module csoir_prescaler #(
   parameter int CNT_W = 8
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clkEn,
   // configuration
   input wire logic srcExternal,
   input wire logic fallingEdge,
   input wire logic assignWatchdog,
   input wire logic [2:0] rateSel,
   input wire logic prescClear,
   // sources
   input wire logic instrCycleTick,
   input wire logic timer0ExtClockPin,
   input wire logic watchdogBaseTick,
   // outputs
   output logic timer0IncTick,
   output logic watchdogPostTick
);
   import csoir_pkg::*;

   function automatic logic [CNT_W-1:0] rateMask(input logic [3:0] span);
      logic [CNT_W:0] one;
      one = {{CNT_W{1'b0}}, 1'b1} << span;
      rateMask = one[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
   endfunction : rateMask

   logic [CNT_W-1:0] cnt_ff;
   logic extPrev_ff;
   logic extEdge;
   logic srcTick;
   logic cntTick;
   logic [3:0] span;
   logic [CNT_W-1:0] mask;
   logic full;

   assign extEdge = fallingEdge ? (extPrev_ff & ~timer0ExtClockPin) : (~extPrev_ff & timer0ExtClockPin);
   assign srcTick = srcExternal ? extEdge : instrCycleTick;
   // one counter only, so the unassigned side always runs undivided
   assign cntTick = assignWatchdog ? watchdogBaseTick : srcTick;
   assign span = assignWatchdog ? {1'b0, rateSel} : ({1'b0, rateSel} + T0_RATE_OFFSET);
   assign mask = rateMask(span);
   assign full = ((cnt_ff & mask) == mask);
   assign timer0IncTick = assignWatchdog ? srcTick : (srcTick & full);
   assign watchdogPostTick = assignWatchdog ? (watchdogBaseTick & full) : watchdogBaseTick;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cnt_ff <= '0;
         extPrev_ff <= 1'b0;
      end else if (clkEn) begin
         extPrev_ff <= timer0ExtClockPin;
         if (prescClear) begin
            cnt_ff <= '0;
         end else if (cntTick) begin
            cnt_ff <= cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

endmodule : csoir_prescaler

`default_nettype wire

// ---- rtl/csoir_regs.sv ----
// Status, option and interrupt register set of an 8-bit core, as data memory.
// Assumes the core drives one access per cycle and pulses instruction events.
`default_nettype none

module csoir_regs (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clkEn,
   // data memory access
   input wire logic [csoir_pkg::ADDR_W-1:0] memAddr,
   input wire logic memWrEn,
   input wire logic [7:0] memWrData,
   input wire logic memRdEn,
   output logic [7:0] memRdData,
   // bank selection to the core
   output logic indirectBank,
   output logic [1:0] directBank,
   // flag computation
   input wire logic flagUpdNull,
   input wire logic flagUpdArith,
   input wire csoir_pkg::csoir_op_e aluOp,
   input wire logic [7:0] aluOpA,
   input wire logic [7:0] aluOpB,
   input wire logic [7:0] aluLogicResult,
   output logic msbOvfFlag,
   // power and watchdog events
   input wire logic watchdogClearInstr,
   input wire logic sleepInstr,
   input wire logic watchdogTimeout,
   // timer sources
   input wire logic instrCycleTick,
   input wire logic timer0ExtClockPin,
   input wire logic watchdogBaseTick,
   input wire logic timer0Overflow,
   output logic timer0IncTick,
   output logic watchdogPostTick,
   // port B
   input wire logic extIrqPin,
   input wire logic [3:0] portBUpperPins,
   input wire logic portBRead,
   input wire logic [7:0] portBLatch,
   output logic [7:0] pullupEnable,
   // interrupts
   input wire logic [7:0] peripheralIrqFlags,
   output logic coreIrq
);
   import csoir_pkg::*;

   // ------------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------------
   function automatic logic regHit(input logic [ADDR_W-1:0] addr, input logic [8:0] target,
                                   input logic [8:0] cmpMask);
      regHit = (((addr ^ target) & cmpMask) == 9'h000);
   endfunction : regHit

   wire hitStatus = regHit(memAddr, ADDR_ARITH_STATUS, MIRROR_ALL_BANKS);
   wire hitIrqCtrl = regHit(memAddr, ADDR_CORE_IRQ_CTRL, MIRROR_ALL_BANKS);
   wire hitOption = regHit(memAddr, ADDR_PRESCALE_OPTION, MIRROR_ODD_BANKS);
   wire hitPeriphEn = regHit(memAddr, ADDR_PERIPH_IRQ_EN, MIRROR_NONE);
   wire statusWr = memWrEn & hitStatus;
   wire irqCtrlWr = memWrEn & hitIrqCtrl;
   wire optionWr = memWrEn & hitOption;
   wire periphEnWr = memWrEn & hitPeriphEn;

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   logic [7:0] status_ff;
   logic [7:0] option_ff;
   logic [7:0] irqCtrl_ff;
   logic [7:0] periphEn_ff;
   logic [7:0] rdData_ff;
   logic [7:0] pullup_ff;
   logic extPrev_ff;
   logic [3:0] portSnap_ff;
   logic [7:0] nxt_status;
   logic [7:0] nxt_irqCtrl;
   logic [7:0] nxt_pullup;
   logic [7:0] rdMux;

   // ------------------------------------------------------------------
   // flag computation
   // ------------------------------------------------------------------
   logic calcNull;
   logic calcNibble;
   logic calcMsb;

   csoir_flag_calc u_flag_calc (
      .aluOp(aluOp),
      .opA(aluOpA),
      .opB(aluOpB),
      .logicResult(aluLogicResult),
      .carryIn(status_ff[BIT_MSB_OVF]),
      .resultNull(calcNull),
      .nibbleOvf(calcNibble),
      .msbOvf(calcMsb)
   );

   // rotates leave the nibble flag alone
   wire nibbleUpd = flagUpdArith & ((aluOp == CSOIR_OP_ADD) | (aluOp == CSOIR_OP_SUB));
   wire flagsBusy = flagUpdNull | flagUpdArith;

   // ------------------------------------------------------------------
   // status next value
   // ------------------------------------------------------------------
   always_comb begin
      nxt_status = status_ff;
      if (statusWr) begin
         nxt_status[BIT_IND_BANK] = memWrData[BIT_IND_BANK];
         nxt_status[BIT_DBANK_HI:BIT_DBANK_LO] = memWrData[BIT_DBANK_HI:BIT_DBANK_LO];
      end
      // computed flags beat a same-instruction write to the register
      if (statusWr & ~flagsBusy) begin
         nxt_status[BIT_RES_NULL:BIT_MSB_OVF] = memWrData[BIT_RES_NULL:BIT_MSB_OVF];
      end
      if (flagUpdNull) begin
         nxt_status[BIT_RES_NULL] = calcNull;
      end
      if (nibbleUpd) begin
         nxt_status[BIT_NIBBLE_OVF] = calcNibble;
      end
      if (flagUpdArith) begin
         nxt_status[BIT_MSB_OVF] = calcMsb;
      end
      if (watchdogClearInstr | sleepInstr) begin
         nxt_status[BIT_WDOG_EXPIRY] = 1'b1;
      end
      if (watchdogTimeout) begin
         nxt_status[BIT_WDOG_EXPIRY] = 1'b0;
      end
      if (watchdogClearInstr) begin
         nxt_status[BIT_POWER_DOWN] = 1'b1;
      end
      if (sleepInstr) begin
         nxt_status[BIT_POWER_DOWN] = 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // interrupt events
   // ------------------------------------------------------------------
   wire extEdgeSel = option_ff[BIT_EXT_EDGE];
   wire extEdge = extEdgeSel ? (extIrqPin & ~extPrev_ff) : (~extIrqPin & extPrev_ff);
   // mismatch keeps re-setting the flag until a port read refreshes the snapshot
   wire portMismatch = (portBUpperPins != portSnap_ff);

   always_comb begin
      nxt_irqCtrl = irqCtrl_ff;
      if (irqCtrlWr) begin
         nxt_irqCtrl = memWrData;
      end
      // events win over a software clear in the same cycle
      if (timer0Overflow) begin
         nxt_irqCtrl[BIT_T0OVF_FLAG] = 1'b1;
      end
      if (extEdge) begin
         nxt_irqCtrl[BIT_EXTPIN_FLAG] = 1'b1;
      end
      if (portMismatch) begin
         nxt_irqCtrl[BIT_PORTCHG_FLAG] = 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // interrupt request
   // ------------------------------------------------------------------
   wire [2:0] coreEnables = irqCtrl_ff[BIT_T0OVF_EN:BIT_PORTCHG_EN];
   wire [2:0] coreFlags = irqCtrl_ff[BIT_T0OVF_FLAG:BIT_PORTCHG_FLAG];
   wire coreReq = |(coreEnables & coreFlags);
   wire periphReq = irqCtrl_ff[BIT_PERIPH_GRP_EN] & (|(periphEn_ff & peripheralIrqFlags));
   assign coreIrq = irqCtrl_ff[BIT_GLOBAL_EN] & (coreReq | periphReq);

   // ------------------------------------------------------------------
   // read path and pull-ups
   // ------------------------------------------------------------------
   assign rdMux = hitStatus ? status_ff :
                  hitIrqCtrl ? irqCtrl_ff :
                  hitOption ? option_ff :
                  hitPeriphEn ? periphEn_ff : 8'h00;
   assign nxt_pullup = option_ff[BIT_PULLUP_DIS] ? 8'h00 : portBLatch;

   // ------------------------------------------------------------------
   // state update
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         status_ff <= RST_ARITH_STATUS;
         option_ff <= RST_PRESCALE_OPTION;
         irqCtrl_ff <= RST_CORE_IRQ_CTRL;
         periphEn_ff <= RST_PERIPH_IRQ_EN;
         rdData_ff <= 8'h00;
         pullup_ff <= 8'h00;
         extPrev_ff <= 1'b0;
         portSnap_ff <= 4'h0;
      end else if (clkEn) begin
         status_ff <= nxt_status;
         irqCtrl_ff <= nxt_irqCtrl;
         pullup_ff <= nxt_pullup;
         extPrev_ff <= extIrqPin;
         if (optionWr) begin
            option_ff <= memWrData;
         end
         if (periphEnWr) begin
            periphEn_ff <= memWrData & PERIPH_IRQ_EN_WR_MASK;
         end
         if (memRdEn) begin
            rdData_ff <= rdMux;
         end
         if (portBRead) begin
            portSnap_ff <= portBUpperPins;
         end
      end
   end

   assign memRdData = rdData_ff;
   assign indirectBank = status_ff[BIT_IND_BANK];
   assign directBank = status_ff[BIT_DBANK_HI:BIT_DBANK_LO];
   assign msbOvfFlag = status_ff[BIT_MSB_OVF];
   assign pullupEnable = pullup_ff;

   // ------------------------------------------------------------------
   // shared prescaler
   // ------------------------------------------------------------------
   // an option write, or a watchdog clear while the prescaler is assigned to the watchdog, restarts the division
   wire prescClear = optionWr | (watchdogClearInstr & option_ff[BIT_PRESC_ASSIGN]);

   csoir_prescaler #(
      .CNT_W(8)
   ) u_prescaler (
      .ref_clk(ref_clk),
      .rst(rst),
      .clkEn(clkEn),
      .srcExternal(option_ff[BIT_T0_SRC]),
      .fallingEdge(option_ff[BIT_T0_EDGE]),
      .assignWatchdog(option_ff[BIT_PRESC_ASSIGN]),
      .rateSel(option_ff[BIT_RATE_HI:BIT_RATE_LO]),
      .prescClear(prescClear),
      .instrCycleTick(instrCycleTick),
      .timer0ExtClockPin(timer0ExtClockPin),
      .watchdogBaseTick(watchdogBaseTick),
      .timer0IncTick(timer0IncTick),
      .watchdogPostTick(watchdogPostTick)
   );

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   property p_bank_write;
      clkEn && statusWr |=> (directBank == $past(memWrData[6:5])) && (indirectBank == $past(memWrData[7]));
   endproperty
   a_bank_write: assert property (p_bank_write) else $error("bank bits not written");

   property p_expiry_clear;
      clkEn && watchdogTimeout |=> !status_ff[BIT_WDOG_EXPIRY];
   endproperty
   a_expiry_clear: assert property (p_expiry_clear) else $error("expiry flag not cleared");

   property p_sleep_pd;
      clkEn && sleepInstr |=> !status_ff[BIT_POWER_DOWN] ##0 status_ff[BIT_WDOG_EXPIRY] == !$past(watchdogTimeout);
   endproperty
   a_sleep_pd: assert property (p_sleep_pd) else $error("sleep did not update power flags");

   property p_status_write_suppressed;
      clkEn && statusWr && flagUpdNull |=> status_ff[BIT_RES_NULL] == $past(calcNull);
   endproperty
   a_status_write_suppressed: assert property (p_status_write_suppressed) else $error("null flag overwritten");

   property p_msb_carry;
      clkEn && flagUpdArith |=> msbOvfFlag == $past(calcMsb);
   endproperty
   a_msb_carry: assert property (p_msb_carry) else $error("msb overflow wrong");

   property p_global_block;
      !irqCtrl_ff[BIT_GLOBAL_EN] |-> !coreIrq;
   endproperty
   a_global_block: assert property (p_global_block) else $error("irq without global enable");

   property p_group_block;
      !irqCtrl_ff[BIT_PERIPH_GRP_EN] && !coreReq |-> !coreIrq;
   endproperty
   a_group_block: assert property (p_group_block) else $error("peripheral irq without group enable");

   property p_ext_flag;
      clkEn && extEdge ##1 (clkEn && !irqCtrlWr)[*2] |-> irqCtrl_ff[BIT_EXTPIN_FLAG];
   endproperty
   a_ext_flag: assert property (p_ext_flag) else $error("external flag lost");

   property p_port_change;
      clkEn && portMismatch |=> irqCtrl_ff[BIT_PORTCHG_FLAG];
   endproperty
   a_port_change: assert property (p_port_change) else $error("port change flag not set");

   property p_pullup_off;
      clkEn && option_ff[BIT_PULLUP_DIS] && !optionWr |=> pullupEnable == 8'h00;
   endproperty
   a_pullup_off: assert property (p_pullup_off) else $error("pull-ups on while disabled");

endmodule : csoir_regs

`default_nettype wire

// ---- dv/csoir_core_model.sv ----
// Core-side partner: issues data-memory reads and writes, one at a time.
// Assumes the bench calls its tasks only after reset has been released.
`default_nettype none

module csoir_core_model (
   // clock
   input wire logic ref_clk,
   // data memory access
   output logic [8:0] memAddr,
   output logic memWrEn,
   output logic [7:0] memWrData,
   output logic memRdEn,
   input wire logic [7:0] memRdData
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      memAddr = 9'h000;
      memWrEn = 1'b0;
      memWrData = 8'h00;
      memRdEn = 1'b0;
   end

   // ------------------------------------------------------------------
   // access tasks
   // ------------------------------------------------------------------
   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      memAddr <= a;
      memWrData <= d;
      memWrEn <= 1'b1;
      @(posedge ref_clk);
      memWrEn <= 1'b0;
      // idle bus shows no stale data
      memWrData <= ~d;
   endtask : wr

   task automatic rd(input logic [8:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      memAddr <= a;
      memRdEn <= 1'b1;
      @(posedge ref_clk);
      memRdEn <= 1'b0;
      @(posedge ref_clk);
      d = memRdData;
   endtask : rd

endmodule : csoir_core_model

`default_nettype wire

// ---- dv/core_status_option_interrupt_regs_bench.sv ----
// Self-checking bench for the status, option and interrupt register set.
// Assumes the core model issues all register accesses.
`default_nettype none
`define CHK(nm, ex, got) begin nCompared++; if ((got) !== (ex)) begin errorCnt++; \
   $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end

module core_status_option_interrupt_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import csoir_pkg::*;

   typedef struct {csoir_op_e op; logic [7:0] a, b, lr; logic nl, ar; logic [7:0] ex;} csoir_row_s;
   csoir_row_s rows [7] = '{'{CSOIR_OP_ADD, 8'h0F, 8'h01, 8'h00, 1'b1, 1'b1, 8'h1A},
      '{CSOIR_OP_ADD, 8'hFF, 8'h01, 8'h00, 1'b1, 1'b1, 8'h1F}, '{CSOIR_OP_SUB, 8'h05, 8'h05, 8'h00, 1'b1, 1'b1, 8'h1F},
      '{CSOIR_OP_SUB, 8'h00, 8'h01, 8'h00, 1'b1, 1'b1, 8'h18},
      '{CSOIR_OP_ROT_RIGHT, 8'h01, 8'h00, 8'h00, 1'b0, 1'b1, 8'h19},
      '{CSOIR_OP_ROT_LEFT, 8'h7F, 8'h00, 8'h00, 1'b0, 1'b1, 8'h18},
      '{CSOIR_OP_LOGIC, 8'h00, 8'h00, 8'h00, 1'b1, 1'b0, 8'h1C}};
   logic [7:0] pOpt [5] = '{8'h00, 8'h03, 8'h0A, 8'h28, 8'h38};
   int pN [5] = '{8, 32, 16, 8, 8};
   int pT0 [5] = '{4, 2, 16, 4, 4};
   int pWd [5] = '{8, 32, 4, 8, 8};

   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic memWrEn, memRdEn, indirectBank, msbOvfFlag, timer0IncTick, watchdogPostTick, coreIrq;
   logic [8:0] memAddr;
   logic [7:0] memWrData, memRdData, pullupEnable, rdVal;
   logic [1:0] directBank;
   logic [4:0] evt = 5'h00;
   logic flagUpdNull = 1'b0, flagUpdArith = 1'b0, instrCycleTick = 1'b0, timer0ExtClockPin = 1'b0;
   logic watchdogBaseTick = 1'b0, extIrqPin = 1'b0, clkEn = 1'b1;
   csoir_op_e aluOp = CSOIR_OP_ADD;
   logic [7:0] aluOpA = 8'h00, aluOpB = 8'h00, aluLogicResult = 8'h00;
   logic [7:0] portBLatch = 8'hA5, peripheralIrqFlags = 8'h00;
   logic [3:0] portBUpperPins = 4'h0;
   int errorCnt = 0, nCompared = 0, t0Cnt = 0, wdCnt = 0, s0, s1;

   always #4 ref_clk = ~ref_clk;
   // mid-cycle count keeps clear of the edge that launches each tick
   always @(negedge ref_clk) begin
      t0Cnt += timer0IncTick;
      wdCnt += watchdogPostTick;
   end

   csoir_regs dut (.ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .memAddr(memAddr), .memWrEn(memWrEn),
      .memWrData(memWrData), .memRdEn(memRdEn), .memRdData(memRdData), .indirectBank(indirectBank),
      .directBank(directBank), .flagUpdNull(flagUpdNull), .flagUpdArith(flagUpdArith), .aluOp(aluOp),
      .aluOpA(aluOpA), .aluOpB(aluOpB), .aluLogicResult(aluLogicResult), .msbOvfFlag(msbOvfFlag),
      .watchdogClearInstr(evt[0]), .sleepInstr(evt[1]), .watchdogTimeout(evt[2]),
      .instrCycleTick(instrCycleTick), .timer0ExtClockPin(timer0ExtClockPin), .watchdogBaseTick(watchdogBaseTick),
      .timer0Overflow(evt[3]), .timer0IncTick(timer0IncTick), .watchdogPostTick(watchdogPostTick),
      .extIrqPin(extIrqPin), .portBUpperPins(portBUpperPins), .portBRead(evt[4]), .portBLatch(portBLatch),
      .pullupEnable(pullupEnable), .peripheralIrqFlags(peripheralIrqFlags), .coreIrq(coreIrq));
   csoir_core_model core (.ref_clk(ref_clk), .memAddr(memAddr), .memWrEn(memWrEn), .memWrData(memWrData),
      .memRdEn(memRdEn), .memRdData(memRdData));

   // ------------------------------------------------------------------
   // helper tasks
   // ------------------------------------------------------------------
   task automatic pulse(input int i);
      @(posedge ref_clk);
      evt[i] <= 1'b1;
      @(posedge ref_clk);
      evt[i] <= 1'b0;
   endtask : pulse

   task automatic rchk(input logic [8:0] a, input logic [7:0] ex);
      core.rd(a, rdVal);
      `CHK("rd", ex, rdVal)
   endtask : rchk

   task automatic wrd(input logic [8:0] w, input logic [8:0] r, input logic [7:0] d, input logic [7:0] ex);
      core.wr(w, d);
      rchk(r, ex);
   endtask : wrd

   task automatic irq(input logic [7:0] d, input logic ex);
      core.wr(9'h00B, d);
      @(posedge ref_clk);
      `CHK("irq", ex, coreIrq)
   endtask : irq

   task testDone;
      if (errorCnt == 0 && nCompared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : testDone

   initial begin
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      foreach (rows[i]) begin
         fork
            core.wr(9'h003, 8'h07);
            begin
               @(posedge ref_clk);
               aluOp <= rows[i].op;
               {aluOpA, aluOpB, aluLogicResult} <= {rows[i].a, rows[i].b, rows[i].lr};
               {flagUpdNull, flagUpdArith} <= {rows[i].nl, rows[i].ar};
               @(posedge ref_clk);
               {flagUpdNull, flagUpdArith} <= 2'b00;
            end
         join
         rchk(9'h003, rows[i].ex);
         `CHK("msbOvf", rows[i].ex[0], msbOvfFlag)
      end
      rst <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      `CHK("pullup", 8'h00, pullupEnable)
      // rising edge selected out of reset; pin starts low
      extIrqPin <= 1'b1;
      rchk(9'h003, 8'h18);
      rchk(9'h08B, 8'h02);
      rchk(9'h181, 8'hFF);
      rchk(9'h08C, 8'h00);
      wrd(9'h003, 9'h183, 8'hE7, 8'hFF);
      `CHK("bank", 3'h7, {indirectBank, directBank})
      wrd(9'h08C, 9'h08C, 8'hFF, 8'h4F);
      wrd(9'h181, 9'h081, 8'h00, 8'h00);
      wrd(9'h10B, 9'h00B, 8'h38, 8'h38);
      wrd(9'h105, 9'h105, 8'hAA, 8'h00);
      repeat (2) @(posedge ref_clk);
      `CHK("pullup", 8'hA5, pullupEnable)
      core.wr(9'h081, 8'h80);
      repeat (2) @(posedge ref_clk);
      `CHK("pullup", 8'h00, pullupEnable)
      core.wr(9'h081, 8'h00);
      pulse(1);
      rchk(9'h003, 8'hF7);
      pulse(2);
      rchk(9'h003, 8'hE7);
      pulse(0);
      rchk(9'h003, 8'hFF);
      pulse(3);
      rchk(9'h00B, 8'h3C);
      `CHK("irq", 1'b0, coreIrq)
      irq(8'hA4, 1'b1);
      irq(8'hA0, 1'b0);
      @(posedge ref_clk);
      extIrqPin <= 1'b1;
      repeat (2) @(posedge ref_clk);
      extIrqPin <= 1'b0;
      rchk(9'h00B, 8'hA2);
      `CHK("irq", 1'b0, coreIrq)
      peripheralIrqFlags <= 8'h01;
      irq(8'h80, 1'b0);
      irq(8'hC0, 1'b1);
      peripheralIrqFlags <= 8'h00;
      portBUpperPins <= 4'h5;
      wrd(9'h00B, 9'h00B, 8'h00, 8'h01);
      pulse(4);
      wrd(9'h00B, 9'h00B, 8'h00, 8'h00);
      // frozen clock enable must swallow an overflow event
      clkEn <= 1'b0;
      pulse(3);
      clkEn <= 1'b1;
      rchk(9'h00B, 8'h00);
      foreach (pOpt[i]) begin
         core.wr(9'h081, pOpt[i]);
         s0 = t0Cnt;
         s1 = wdCnt;
         repeat (pN[i]) begin
            @(posedge ref_clk);
            {instrCycleTick, watchdogBaseTick, timer0ExtClockPin} <= {2'b11, ~timer0ExtClockPin};
            @(posedge ref_clk);
            {instrCycleTick, watchdogBaseTick} <= 2'b00;
         end
         @(posedge ref_clk);
         `CHK("t0", pT0[i], t0Cnt - s0)
         `CHK("wd", pWd[i], wdCnt - s1)
      end
      testDone();
   end

endmodule : core_status_option_interrupt_regs_bench

`default_nettype wire
